// >>> verilog/cap_pwm.sv
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - All channels in PWM modes share one cycle length select field.
// - Other channels keep their own mode registers, set independently.
// - In 8-bit PWM the pin goes high when low byte equals compare.
// - In 8-bit PWM the pin goes low when the low byte overflows.
// - In 8-bit PWM, on low byte rollover the compare low byte reloads from the high byte.
// - 8-bit PWM needs comparator enable, PWM select and length select zero.
// - With match flag enable set, each rising output edge sets event flag.
// - Each low byte overflow sets the overflow flag, every 256 cycles.
// - Writing the compare low byte clears comparator enable.
// - Writing the compare high byte sets comparator enable.
// - High time is 256 minus compare high; zero means always high.
// - Comparator enable cleared gives a constantly low output.
module cap_pwm (
	input wire logic sys_clk, // 10 MHz clock, also timebase
	input wire logic srst, // Synchronous reset, active high
	input wire logic [3:0] reg_addr, // Register address
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [7:0] reg_rdata, // Read data, cycle after strobe
	output logic [cap_pkg::CAP_NCH-1:0] module_output_pin, // PWM outputs
	output logic irq // Interrupt level
);
	import cap_pkg::*;

	typedef struct packed {
		logic [7:0] cfg;
		logic [CAP_NCH-1:0][7:0] mode;
		logic [CAP_NCH-1:0][7:0] cpl;
		logic [CAP_NCH-1:0][7:0] cph;
		logic [CAP_NST-1:0] status;
		logic [CAP_NST-1:0] enable;
		logic [7:0] rdata;
		logic irq;
	} cap_top_state_t;

	cap_top_state_t s_reg, s_next;
	logic cnt_load;
	logic [CAP_NCH-1:0] ch_evt;
	logic [CAP_NST-1:0] evt;
	logic [CAP_NST-1:0] clr;
	logic [1:0] cycle_length_select;

	cap_tb_if tb_bus();

	// Shared length field for every channel
	assign cycle_length_select = s_reg.cfg[CFG_CYCLE_LENGTH_SELECT +: 2];

	// Software load of the counter low byte
	assign cnt_load = reg_wr && (reg_addr == ADDR_CNT_LO);

	// Timebase counter
	cap_counter u_counter (
		.sys_clk(sys_clk),
		.srst(srst),
		.run(s_reg.cfg[CFG_RUN]),
		.load_lo(cnt_load),
		.load_val(reg_wdata),
		.tb(tb_bus.src)
	);

	// One comparator channel per module
	for (genvar i = 0; i < CAP_NCH; i++) begin : g_ch
		cap_channel u_channel (
			.sys_clk(sys_clk),
			.srst(srst),
			.tb(tb_bus.snk),
			.mode(s_reg.mode[i]),
			.cycle_length_select(cycle_length_select),
			.cpl(s_reg.cpl[i]),
			.cph(s_reg.cph[i]),
			.pin(module_output_pin[i]),
			.match_evt(ch_evt[i])
		);
	end

	// Event sources and software clears
	assign evt = {ch_evt, tb_bus.wrap};
	assign clr = (reg_wr && reg_addr == ADDR_CLEAR) ? reg_wdata[CAP_NST-1:0] : '0;

	// Next state of the register file
	always_comb begin
		s_next = s_reg;
		s_next.rdata = RST_RDATA;

		// Automatic compare reload at low byte rollover
		for (int i = 0; i < CAP_NCH; i++) begin
			if (tb_bus.wrap && cap_is_pwm8(s_reg.mode[i], cycle_length_select)) begin
				s_next.cpl[i] = s_reg.cph[i];
			end
		end

		// Register writes, after the reload so software wins
		if (reg_wr) begin
			if (reg_addr == ADDR_PWM_CFG) begin
				s_next.cfg = reg_wdata & CFG_WMASK;
			end
			if (reg_addr == ADDR_ENABLE) begin
				s_next.enable = reg_wdata[CAP_NST-1:0];
			end
			for (int i = 0; i < CAP_NCH; i++) begin
				// Whole mode byte kept per channel
				if (reg_addr == cap_ch_addr(i, OFS_MODE)) begin
					s_next.mode[i] = reg_wdata;
				end
				// Low byte write turns the comparator off
				if (reg_addr == cap_ch_addr(i, OFS_CPL)) begin
					s_next.cpl[i] = reg_wdata;
					s_next.mode[i][MODE_ECOM] = 1'b0;
				end
				// High byte write turns the comparator on
				if (reg_addr == cap_ch_addr(i, OFS_CPH)) begin
					s_next.cph[i] = reg_wdata;
					s_next.mode[i][MODE_ECOM] = 1'b1;
				end
			end
		end

		// Sticky flags, a new event beats a clear
		s_next.status = (s_reg.status & ~clr) | evt;

		// Interrupt level from enabled flags
		s_next.irq = |(s_next.status & s_next.enable);

		// Read mux, data valid one cycle after the strobe
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_CNT_LO: s_next.rdata = tb_bus.count[7:0];
				ADDR_CNT_HI: s_next.rdata = tb_bus.count[15:8];
				ADDR_PWM_CFG: s_next.rdata = s_reg.cfg;
				ADDR_STATUS: s_next.rdata = 8'(s_reg.status);
				ADDR_ENABLE: s_next.rdata = 8'(s_reg.enable);
				default: begin
					s_next.rdata = RST_RDATA;
					for (int i = 0; i < CAP_NCH; i++) begin
						if (reg_addr == cap_ch_addr(i, OFS_MODE)) begin
							s_next.rdata = s_reg.mode[i];
						end
						if (reg_addr == cap_ch_addr(i, OFS_CPL)) begin
							s_next.rdata = s_reg.cpl[i];
						end
						if (reg_addr == cap_ch_addr(i, OFS_CPH)) begin
							s_next.rdata = s_reg.cph[i];
						end
					end
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_reg.cfg <= RST_CFG;
			s_reg.mode <= {CAP_NCH{RST_MODE}};
			s_reg.cpl <= {CAP_NCH{RST_CMP}};
			s_reg.cph <= {CAP_NCH{RST_CMP}};
			s_reg.status <= '0;
			s_reg.enable <= '0;
			s_reg.rdata <= RST_RDATA;
			s_reg.irq <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata = s_reg.rdata;
	assign irq = s_reg.irq;

	// Checks on the register side
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	// Steps of a compare update on channel 0
	sequence seq_cpl_wr0;
		reg_wr && reg_addr == cap_ch_addr(0, OFS_CPL);
	endsequence

	sequence seq_cph_wr0;
		reg_wr && reg_addr == cap_ch_addr(0, OFS_CPH);
	endsequence

	sequence seq_wrap_pwm8_0;
		tb_bus.wrap && cap_is_pwm8(s_reg.mode[0], cycle_length_select) && !(reg_wr && reg_addr == cap_ch_addr(0, OFS_CPL));
	endsequence

	property p_reload;
		seq_wrap_pwm8_0 |=> s_reg.cpl[0] == $past(s_reg.cph[0]);
	endproperty

	property p_ordered_update;
		seq_cpl_wr0 ##[1:2] seq_cph_wr0 |=> s_reg.mode[0][MODE_ECOM] && s_reg.cph[0] == $past(reg_wdata);
	endproperty

	chk_cpl_reload: assert property (p_reload)
		else $error("compare low byte not reloaded at overflow");
	chk_cpl_clears_en: assert property (seq_cpl_wr0 |=> !s_reg.mode[0][MODE_ECOM])
		else $error("low byte write left comparator on");
	chk_cph_sets_en: assert property (seq_cph_wr0 |=> s_reg.mode[0][MODE_ECOM])
		else $error("high byte write left comparator off");
	chk_ordered_update: assert property (p_ordered_update)
		else $error("low then high write did not enable");
	chk_cycle_overflow_flag_set: assert property (tb_bus.wrap |=> s_reg.status[STAT_CYCLE_OVERFLOW_FLAG])
		else $error("overflow flag not set");
	chk_event_set: assert property (ch_evt[0] |=> s_reg.status[STAT_EV0])
		else $error("event flag not set on match");
	chk_flag_sticky: assert property (s_reg.status[STAT_CYCLE_OVERFLOW_FLAG] && clr[STAT_CYCLE_OVERFLOW_FLAG] == 1'b0 |=> s_reg.status[STAT_CYCLE_OVERFLOW_FLAG])
		else $error("overflow flag dropped without a clear");
	chk_irq_level: assert property (s_reg.irq == (|(s_reg.status & s_reg.enable)))
		else $error("interrupt does not follow enabled flags");
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == RST_RDATA)
		else $error("read data outside the answer cycle");
	chk_rdata_status: assert property (reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata == 8'($past(s_reg.status)))
		else $error("status read returned wrong value");
	chk_shared_len: assert property (cycle_length_select != CYCLE_LENGTH_SELECT_8BIT |-> !cap_is_pwm8(s_reg.mode[0], cycle_length_select)
		&& !cap_is_pwm8(s_reg.mode[1], cycle_length_select))
		else $error("8-bit mode active with other length");
endmodule : cap_pwm

// >>> verilog/cap_pkg.sv
package cap_pkg;
	// Channel count and status width
	localparam int CAP_NCH = 2;
	localparam int CAP_NST = CAP_NCH + 1;
	// Register offsets
	localparam logic [3:0] ADDR_CNT_LO = 4'h0;
	localparam logic [3:0] ADDR_CNT_HI = 4'h1;
	localparam logic [3:0] ADDR_PWM_CFG = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam logic [3:0] ADDR_CLEAR = 4'h4;
	localparam logic [3:0] ADDR_ENABLE = 4'h5;
	localparam logic [3:0] ADDR_CH_BASE = 4'h8;
	// Per-channel offsets inside a four-word slot
	localparam logic [1:0] OFS_MODE = 2'h0;
	localparam logic [1:0] OFS_CPL = 2'h1;
	localparam logic [1:0] OFS_CPH = 2'h2;
	// Field positions
	localparam int MODE_MAT = 0;
	localparam int MODE_PWM = 1;
	localparam int MODE_ECOM = 2;
	localparam int CFG_CYCLE_LENGTH_SELECT = 0;
	localparam int CFG_RUN = 7;
	localparam int STAT_CYCLE_OVERFLOW_FLAG = 0;
	localparam int STAT_EV0 = 1;
	// Encodings and masks
	localparam logic [1:0] CYCLE_LENGTH_SELECT_8BIT = 2'h0;
	localparam logic [7:0] LO_MAX = 8'hFF;
	localparam logic [7:0] LO_ZERO = 8'h00;
	localparam logic [7:0] CFG_WMASK = 8'h83;
	// Values after reset
	localparam logic [7:0] RST_CFG = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_CMP = 8'h00;
	localparam logic [7:0] RST_RDATA = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	// Timebase cycles in one 8-bit period
	localparam int PWM8_PERIOD = 256;

	// Address of one channel register
	function automatic logic [3:0] cap_ch_addr(input int ch, input logic [1:0] ofs);
		cap_ch_addr = ADDR_CH_BASE + {ch[1:0], ofs};
	endfunction : cap_ch_addr

	// Channel runs 8-bit PWM
	function automatic logic cap_is_pwm8(input logic [7:0] mode, input logic [1:0] cycle_length_select);
		cap_is_pwm8 = mode[MODE_ECOM] && mode[MODE_PWM] && (cycle_length_select == CYCLE_LENGTH_SELECT_8BIT);
	endfunction : cap_is_pwm8
endpackage : cap_pkg

// >>> verilog/cap_tb_if.sv
`timescale 1ns/1ps
// Timebase shared by all channels
interface cap_tb_if;
	logic [15:0] count; // Current count
	logic [15:0] count_next; // Count after this edge
	logic wrap; // Low byte rolls over at this edge
	modport src (output count, output count_next, output wrap);
	modport snk (input count, input count_next, input wrap);
endinterface : cap_tb_if

// >>> verilog/cap_counter.sv
`timescale 1ns/1ps
module cap_counter (
	input wire logic sys_clk, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic run, // Count enable
	input wire logic load_lo, // Software writes low byte
	input wire logic [7:0] load_val, // Value written
	cap_tb_if.src tb // Timebase to channels
);
	import cap_pkg::*;

	typedef struct packed {
		logic [15:0] count;
		logic [8:0] gap;
		logic steady;
	} cap_cnt_state_t;

	cap_cnt_state_t s_reg, s_next;
	logic wrap;

	// Low byte rolls over on a counting edge
	assign wrap = run && !load_lo && (s_reg.count[7:0] == LO_MAX);

	// Next count, software load wins
	always_comb begin
		s_next = s_reg;
		if (load_lo) begin
			s_next.count[7:0] = load_val;
		end else if (run) begin
			s_next.count = s_reg.count + 16'h0001;
		end
		s_next.gap = wrap ? 9'h000 : s_reg.gap + 9'h001;
		s_next.steady = wrap ? 1'b1 : (s_reg.steady && run && !load_lo);
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_reg.count <= RST_COUNT;
			s_reg.gap <= 9'h000;
			s_reg.steady <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tb.count = s_reg.count;
	assign tb.count_next = s_next.count;
	assign tb.wrap = wrap;

	chk_wrap_to_zero: assert property (@(posedge sys_clk) disable iff (srst) wrap |=> s_reg.count[7:0] == LO_ZERO)
		else $error("low byte did not roll to zero");
	chk_wrap_period: assert property (@(posedge sys_clk) disable iff (srst) wrap && s_reg.steady |-> s_reg.gap == 9'(PWM8_PERIOD - 1))
		else $error("overflow spacing is not one period");
endmodule : cap_counter

// >>> verilog/cap_channel.sv
`timescale 1ns/1ps
module cap_channel (
	input wire logic sys_clk, // System clock
	input wire logic srst, // Synchronous reset
	cap_tb_if.snk tb, // Shared timebase
	input wire logic [7:0] mode, // Module mode register
	input wire logic [1:0] cycle_length_select, // Shared cycle length select
	input wire logic [7:0] cpl, // Compare low byte
	input wire logic [7:0] cph, // Compare high byte
	output logic pin, // Module output pin
	output logic match_evt // Flag event at this edge
);
	import cap_pkg::*;

	typedef struct packed {
		logic pin;
	} cap_ch_state_t;

	cap_ch_state_t s_reg, s_next;
	logic pwm8;
	logic timer;
	logic hit;

	// Mode decode from the shared length field
	assign pwm8 = cap_is_pwm8(mode, cycle_length_select);
	assign timer = mode[MODE_ECOM] && !mode[MODE_PWM];
	// Compare against the value reloaded at a wrap
	assign hit = tb.count_next[7:0] == (tb.wrap ? cph : cpl);

	// Pin set on match, cleared on wrap
	always_comb begin
		s_next = s_reg;
		if (pwm8) begin
			s_next.pin = hit || (s_reg.pin && !tb.wrap);
		end else begin
			s_next.pin = 1'b0;
		end
		match_evt = mode[MODE_MAT] && ((pwm8 && s_next.pin && !s_reg.pin)
			|| (timer && tb.count_next == {cph, cpl}));
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_reg.pin <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pin = s_reg.pin;

	chk_pin_match_set: assert property (@(posedge sys_clk) disable iff (srst)
		pwm8 && !tb.wrap && tb.count_next[7:0] == cpl |=> pin)
		else $error("pin not set on compare match");
	chk_pin_wrap_clear: assert property (@(posedge sys_clk) disable iff (srst)
		pwm8 && tb.wrap && cph != LO_ZERO |=> !pin)
		else $error("pin not cleared on overflow");
	chk_full_duty: assert property (@(posedge sys_clk) disable iff (srst)
		pwm8 && tb.wrap && cph == LO_ZERO |=> pin)
		else $error("zero compare did not hold pin high");
	chk_off_low: assert property (@(posedge sys_clk) disable iff (srst)
		!mode[MODE_ECOM] |=> !pin)
		else $error("pin high with comparator off");
endmodule : cap_channel

// >>> bench/cap_pwm_tb_top.sv
`timescale 1ns/1ps
module cap_pwm_tb_top;
	import cap_pkg::*;
	logic sys_clk;
	logic srst;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic [CAP_NCH-1:0] module_output_pin;
	logic irq;
	int n_fail;
	int samples_checked;
	int hi_cnt [CAP_NCH];
	int rise_cnt [CAP_NCH];

	cap_pwm i_dut (
		.sys_clk(sys_clk),
		.srst(srst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.module_output_pin(module_output_pin),
		.irq(irq)
	);

	// 10 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// Channel register address
	function automatic logic [3:0] ch_a(input int n, input logic [1:0] ofs);
		ch_a = ADDR_CH_BASE + {n[1:0], ofs};
	endfunction : ch_a

	// Ends the run with the verdict
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop

	// Byte compare, four-state safe
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk8

	// Count compare
	task automatic chk_cnt(input string what, input int exp, input int got);
		samples_checked++;
		if (got != exp) begin
			n_fail++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chk_cnt

	// One write cycle; leaves an idle cycle behind
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	// One read cycle; data sampled in the cycle after the strobe
	task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : reg_read

	// Read and compare
	task automatic read_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] d;
		reg_read(a, d);
		chk8(what, exp, d);
	endtask : read_chk

	// Interrupt level after register writes have landed
	task automatic chk_irq(input logic exp);
		repeat (2) @(posedge sys_clk);
		#1;
		chk8("irq", {7'h00, exp}, {7'h00, irq});
	endtask : chk_irq

	// High time and rising edges of each pin over one period
	task automatic measure;
		logic [CAP_NCH-1:0] prev;
		#1;
		prev = module_output_pin;
		for (int n = 0; n < CAP_NCH; n++) begin
			hi_cnt[n] = 0;
			rise_cnt[n] = 0;
		end
		repeat (PWM8_PERIOD) begin
			@(posedge sys_clk);
			#1;
			for (int n = 0; n < CAP_NCH; n++) begin
				if (module_output_pin[n] === 1'b1) hi_cnt[n]++;
				if (module_output_pin[n] === 1'b1 && prev[n] === 1'b0) rise_cnt[n]++;
			end
			prev = module_output_pin;
		end
	endtask : measure

	// Watchdog
	initial begin
		repeat (20000) @(posedge sys_clk);
		$display("[ERR] watchdog expired");
		n_fail++;
		report_and_stop();
	end

	// Test sequence
	initial begin
		n_fail = 0;
		samples_checked = 0;
		srst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (12) @(posedge sys_clk);
		srst <= 1'b0;

		// Reset values and unmapped places
		read_chk("config", ADDR_PWM_CFG, RST_CFG);
		read_chk("status", ADDR_STATUS, 8'h00);
		read_chk("enable", ADDR_ENABLE, 8'h00);
		read_chk("mode0", ch_a(0, OFS_MODE), RST_MODE);
		read_chk("cph1", ch_a(1, OFS_CPH), RST_CMP);
		reg_write(4'h6, 8'hFF);
		read_chk("unmapped", 4'h6, 8'h00);
		read_chk("clear", ADDR_CLEAR, 8'h00);
		$display("test reset values done");

		// Compare writes and their side effect on comparator enable
		reg_write(ch_a(0, OFS_MODE), 8'h03);
		reg_write(ch_a(0, OFS_CPL), 8'h10);
		read_chk("mode0 after cpl", ch_a(0, OFS_MODE), 8'h03);
		reg_write(ch_a(0, OFS_CPH), 8'hC0);
		read_chk("mode0 after cph", ch_a(0, OFS_MODE), 8'h07);
		read_chk("cpl0", ch_a(0, OFS_CPL), 8'h10);
		reg_write(ch_a(1, OFS_MODE), 8'h02);
		reg_write(ch_a(1, OFS_CPL), 8'h00);
		reg_write(ch_a(1, OFS_CPH), 8'h00);
		read_chk("mode1", ch_a(1, OFS_MODE), 8'h06);
		$display("test compare writes done");

		// Duty cycle once the compare low byte has reloaded
		reg_write(ADDR_PWM_CFG, 8'h80);
		repeat (300) @(posedge sys_clk);
		measure();
		chk_cnt("ch0 high time", 256 - 8'hC0, hi_cnt[0]);
		chk_cnt("ch0 rising edges", 1, rise_cnt[0]);
		chk_cnt("ch1 high time", 256, hi_cnt[1]);
		chk_cnt("ch1 rising edges", 0, rise_cnt[1]);
		$display("test duty cycle done");

		// Sticky flags, mask and clear
		reg_write(ADDR_PWM_CFG, 8'h00);
		repeat (20) @(posedge sys_clk);
		read_chk("status sticky", ADDR_STATUS, 8'h03);
		chk_irq(1'b0);
		reg_write(ADDR_ENABLE, 8'h02);
		chk_irq(1'b1);
		read_chk("enable", ADDR_ENABLE, 8'h02);
		reg_write(ADDR_CLEAR, 8'h02);
		chk_irq(1'b0);
		read_chk("status after clear", ADDR_STATUS, 8'h01);
		reg_write(ADDR_ENABLE, 8'h01);
		chk_irq(1'b1);
		reg_write(ADDR_CLEAR, 8'h07);
		chk_irq(1'b0);
		read_chk("status cleared", ADDR_STATUS, 8'h00);
		$display("test flags done");

		// Comparator off and wrong cycle length give a low pin
		reg_write(ch_a(0, OFS_CPL), 8'h10);
		reg_write(ADDR_PWM_CFG, 8'h80);
		repeat (300) @(posedge sys_clk);
		measure();
		chk_cnt("ch0 comparator off", 0, hi_cnt[0]);
		chk_cnt("ch1 still running", 256, hi_cnt[1]);
		reg_write(ADDR_PWM_CFG, 8'h81);
		repeat (4) @(posedge sys_clk);
		measure();
		chk_cnt("ch1 other length", 0, hi_cnt[1]);
		$display("test pin off done");

		report_and_stop();
	end
endmodule : cap_pwm_tb_top
